//--- include/bsc_defs.svh
// Constants for the burner safety sequence control block.
// Assumes one 10 MHz system clock; all timers run on a one-second tick.
`ifndef BSC_DEFS_SVH
`define BSC_DEFS_SVH
`define BSC_CLK_HZ     10000000
`define BSC_TICK_S     1
`define BSC_S_PER_H    3600
`define BSC_S_PER_M    60
`define BSC_SAFE_MAX_S 30
`define BSC_FORCE_H    23
`define BSC_FORCE_M    50
`define BSC_OFF_H      24
`define BSC_REP_UNLIM  5'h10
`define BSC_REP_MIN    5'h01
`define BSC_NOFL_MAX   2'h3
`define BSC_NCAUSE     5
`define BSC_C_START    3'h0
`endif

//--- include/bsc_pkg.sv
// Types for the burner safety sequence control block.
// Constants live in bsc_defs.svh; this package holds types only.
package bsc_pkg;
    // Sequence phases, one-hot
    typedef enum logic [7:0] {
        PH_STBY = 8'h01,
        PH_TRAV = 8'h02,
        PH_P1   = 8'h04,
        PH_P32  = 8'h08,
        PH_P3   = 8'h10,
        PH_RUN  = 8'h20,
        PH_SAFE = 8'h40,
        PH_LOCK = 8'h80
    } bsc_phase_t;

    // Fault events; bit index is the repetition counter index
    typedef struct packed {
        logic no_flame;
        logic heavy_oil;
        logic flame_loss;
        logic loop_open;
        logic start_rel;
    } bsc_fault_t;

    // Whole state of the control block
    typedef struct packed {
        bsc_phase_t      phase;
        logic            loaded;
        logic [4:0][4:0] lim;
        logic [4:0][3:0] rep;
        logic [2:0]      cause;
        logic            post_fault;
        logic [23:0]     div;
        logic            tick;
        logic [16:0]     tmr;
        logic [16:0]     off_tmr;
        logic [7:0]      pv_tmr;
        logic [8:0]      t30;
        logic [8:0]      t34;
        logic            fan;
        logic            loop_relay;
        logic            alarm_relay;
        logic            damper_pre;
        logic            show_block;
    } bsc_state_t;
endpackage

//--- verilog/bsc_ctrl.sv
// Burner safety phase, repetition counters, start prevention signalling,
// forced intermittent shutdown and prepurge time allocation.
// Assumes all inputs synchronous to clk_sys; settings are whole seconds.
`timescale 1ns/1ps
`include "bsc_defs.svh"

module bsc_ctrl
    import bsc_pkg::*;
#(
    parameter int TICK_CYC  = `BSC_CLK_HZ * `BSC_TICK_S,
    parameter int FORCE_CNT = (`BSC_FORCE_H * `BSC_S_PER_H + `BSC_FORCE_M * `BSC_S_PER_M)
                              / `BSC_TICK_S,
    parameter int OFF_CNT   = `BSC_OFF_H * `BSC_S_PER_H / `BSC_TICK_S
) (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       heat_req,
    input  wire logic       start_ok,
    input  wire logic       fuel_oil,
    input  wire logic       direct_start,
    input  wire logic       damper_at_pre,
    input  wire logic       phase32_done,
    input  wire bsc_fault_t fault,
    input  wire logic       gas_int,
    input  wire logic       safety_test_done,
    input  wire logic       safety_checks_ok,
    input  wire logic       manual_reset,
    input  wire logic [4:0] lim_start_rel,
    input  wire logic [4:0] lim_loop,
    input  wire logic [4:0] lim_flame_loss,
    input  wire logic [4:0] lim_heavy_oil,
    input  wire logic [1:0] lim_no_flame,
    input  wire logic [7:0] start_block_display_delay,
    input  wire logic       start_block_alarm_enable,
    input  wire logic [7:0] alarm_contact_signal_delay,
    input  wire logic       standby_fault_enable,
    input  wire logic       periodic_forced_shutdown_enable,
    input  wire logic [7:0] purge_total_min_gas,
    input  wire logic [7:0] purge_total_min_oil,
    input  wire logic [7:0] purge_after_fault_gas,
    input  wire logic [7:0] purge_after_fault_oil,
    input  wire logic [7:0] purge_part_one_gas,
    input  wire logic [7:0] purge_part_one_oil,
    input  wire logic [7:0] purge_part_three_gas,
    input  wire logic [7:0] purge_part_three_oil,
    input  wire logic       purge_bypass_gas,
    input  wire logic       purge_bypass_oil,
    output bsc_phase_t      phase,
    output logic            fan_on,
    output logic            loop_relay_on,
    output logic            alarm_relay_on,
    output logic            damper_prepurge,
    output logic            start_block_display
);
    bsc_state_t s;
    bsc_state_t n;

    // Clamp a repetition limit into 1..16; zero is read as one
    function automatic logic [4:0] fix_lim(input logic [4:0] v);
        logic [4:0] r;
        r = v;
        if (v < `BSC_REP_MIN) begin
            r = `BSC_REP_MIN;
        end else if (v > `BSC_REP_UNLIM) begin
            r = `BSC_REP_UNLIM;
        end
        return r;
    endfunction

    logic       pv;
    logic       act;
    logic       ex;
    logic [4:0] fv;
    logic [2:0] cs;
    logic [8:0] tot;
    logic [8:0] aft;
    logic [8:0] p1;
    logic [8:0] p3;
    logic [8:0] sum;
    logic [8:0] base;
    logic [8:0] total;
    logic [8:0] a30;
    logic [8:0] b34;
    logic       byp;

    // Fuel-specific purge settings
    assign tot = {1'b0, fuel_oil ? purge_total_min_oil : purge_total_min_gas};
    assign aft = {1'b0, fuel_oil ? purge_after_fault_oil : purge_after_fault_gas};
    assign p1  = {1'b0, fuel_oil ? purge_part_one_oil : purge_part_one_gas};
    assign p3  = {1'b0, fuel_oil ? purge_part_three_oil : purge_part_three_gas};
    assign byp = fuel_oil ? purge_bypass_oil : purge_bypass_gas;

    // Purge allocation; settings are 8-bit so the sum never wraps
    assign sum   = p1 + p3;
    assign base  = s.post_fault ? aft : tot;
    assign total = (sum > base) ? sum : base;
    assign a30   = (s.post_fault && (total >> 1) > p1) ? (total >> 1) : p1;
    assign b34   = (total - a30 > p3) ? total - a30 : p3;

    // Prevention and fault qualification
    assign pv  = heat_req && !start_ok && s.phase == PH_STBY;
    assign act = s.phase inside {PH_TRAV, PH_P1, PH_P32, PH_P3, PH_RUN};
    assign fv  = fault;
    assign ex  = s.lim[s.cause] != `BSC_REP_UNLIM &&
                 ({1'b0, s.rep[s.cause]} + 5'h01 >= s.lim[s.cause]);

    // Lowest index wins when several causes arrive together
    always_comb begin
        cs = `BSC_C_START;
        for (int i = `BSC_NCAUSE - 1; i >= 0; i--) begin
            if (fv[i]) begin
                cs = 3'(i);
            end
        end
    end

    // Next state of the whole block
    always_comb begin
        n      = s;
        n.tick = 1'b0;
        if (s.div == 24'(TICK_CYC - 1)) begin
            n.div  = '0;
            n.tick = 1'b1;
        end else begin
            n.div = s.div + 24'h1;
        end
        if (s.tick && s.tmr != '1) begin
            n.tmr = s.tmr + 17'h1;
        end

        // Limits latched once after reset, so writes wait for reset
        if (!s.loaded) begin
            n.lim[0] = fix_lim(lim_start_rel);
            n.lim[1] = fix_lim(lim_loop);
            n.lim[2] = fix_lim(lim_flame_loss);
            n.lim[3] = fix_lim(lim_heavy_oil);
            n.lim[4] = {3'h0, (lim_no_flame == 2'h0) ? 2'h1 : lim_no_flame};
            n.loaded = 1'b1;
        end

        // Prevention timer restarts at each new onset
        if (!pv) begin
            n.pv_tmr = '0;
        end else if (s.tick && s.pv_tmr != '1) begin
            n.pv_tmr = s.pv_tmr + 8'h1;
        end

        case (s.phase)
            PH_STBY: begin
                if (s.tick && s.off_tmr != '1) begin
                    n.off_tmr = s.off_tmr + 17'h1;
                end
                if (s.off_tmr > 17'(OFF_CNT)) begin
                    n.post_fault = 1'b1;
                end
                if (standby_fault_enable && !start_ok && s.loaded) begin
                    n.phase = PH_SAFE;
                    n.cause = `BSC_C_START;
                    n.tmr   = '0;
                end else if (heat_req && start_ok && s.loaded) begin
                    n.phase   = PH_TRAV;
                    n.tmr     = '0;
                    n.off_tmr = '0;
                    n.t30     = a30;
                    n.t34     = b34;
                    // Bypass only on a normal, fault-free start
                    if (byp && !s.post_fault && !direct_start) begin
                        n.t30 = '0;
                        n.t34 = '0;
                    end
                end
            end
            PH_TRAV: begin
                if (damper_at_pre) begin
                    n.phase = PH_P1;
                    n.tmr   = '0;
                end
            end
            PH_P1: begin
                if (s.tmr >= {8'h0, s.t30}) begin
                    n.phase = PH_P32;
                    n.tmr   = '0;
                end
            end
            PH_P32: begin
                if (phase32_done) begin
                    n.phase = PH_P3;
                    n.tmr   = '0;
                end
            end
            PH_P3: begin
                if (s.tmr >= {8'h0, s.t34}) begin
                    n.phase      = PH_RUN;
                    n.tmr        = '0;
                    n.post_fault = 1'b0;
                end
            end
            PH_RUN: begin
                // Brief shutdown; restart follows from standby
                if (!heat_req || (periodic_forced_shutdown_enable &&
                                  s.tmr >= 17'(FORCE_CNT))) begin
                    n.phase = PH_STBY;
                    n.tmr   = '0;
                end
            end
            PH_SAFE: begin
                // Checks end early; otherwise the timeout ends it
                if (safety_test_done || s.tmr >= 17'(`BSC_SAFE_MAX_S)) begin
                    n.tmr = '0;
                    if (!safety_checks_ok || ex) begin
                        n.phase = PH_LOCK;
                    end else begin
                        n.phase = PH_STBY;
                        if (s.rep[s.cause] != '1) begin
                            n.rep[s.cause] = s.rep[s.cause] + 4'h1;
                        end
                    end
                end
            end
            PH_LOCK: begin
                if (manual_reset) begin
                    n.phase      = PH_STBY;
                    n.post_fault = 1'b1;
                    n.rep        = '0;
                    n.tmr        = '0;
                end
            end
            default: begin
                n.phase = PH_LOCK;
            end
        endcase

        // Faults in the start-up and run phases open the safety phase
        if (act && (|fv || gas_int)) begin
            n.phase = PH_SAFE;
            n.tmr   = '0;
            n.cause = gas_int ? `BSC_C_START : cs;
            if (gas_int) begin
                n.post_fault = 1'b1;
            end
        end

        // Outputs other than the prevention display follow the next phase so they line up with it
        case (n.phase)
            PH_STBY:                     n.fan = 1'b0;
            PH_SAFE, PH_LOCK:            n.fan = s.fan;
            default:                     n.fan = 1'b1;
        endcase
        n.loop_relay  = !(n.phase inside {PH_SAFE, PH_LOCK});
        n.damper_pre  = n.phase == PH_TRAV;
        n.show_block  = pv && s.pv_tmr >= start_block_display_delay;
        // Safety phase never raises the alarm
        n.alarm_relay = n.phase == PH_LOCK ||
                        (start_block_alarm_enable && pv && n.phase == PH_STBY &&
                         s.pv_tmr >= alarm_contact_signal_delay);
    end

    // Single state register; power-on counts as a post-fault start
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s            <= '0;
            s.phase      <= PH_STBY;
            s.post_fault <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign phase               = s.phase;
    assign fan_on              = s.fan;
    assign loop_relay_on       = s.loop_relay;
    assign alarm_relay_on      = s.alarm_relay;
    assign damper_prepurge     = s.damper_pre;
    assign start_block_display = s.show_block;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence q_leave_safe;
        s.phase == PH_SAFE ##1 s.phase != PH_SAFE;
    endsequence

    sequence q_lock_hold;
        s.phase == PH_LOCK && !manual_reset;
    endsequence

    property p_safe_relays;
        s.phase == PH_SAFE |-> !loop_relay_on && !alarm_relay_on;
    endproperty
    a_safe_relays: assert property (p_safe_relays)
        else $error("relay active in safety phase");

    property p_safe_fan;
        s.phase == PH_SAFE |-> fan_on == $past(fan_on);
    endproperty
    a_safe_fan: assert property (p_safe_fan)
        else $error("fan changed in safety phase");

    property p_safe_exit;
        q_leave_safe |-> s.phase inside {PH_STBY, PH_LOCK};
    endproperty
    a_safe_exit: assert property (p_safe_exit)
        else $error("safety phase left to a wrong phase");

    property p_safe_len;
        s.phase == PH_SAFE |-> s.tmr <= 17'(`BSC_SAFE_MAX_S);
    endproperty
    a_safe_len: assert property (p_safe_len)
        else $error("safety phase overran");

    property p_unlim;
        s.phase == PH_SAFE && s.lim[s.cause] == `BSC_REP_UNLIM && safety_checks_ok
        |=> s.phase != PH_LOCK;
    endproperty
    a_unlim: assert property (p_unlim)
        else $error("lockout with unlimited repetitions");

    property p_block_cause;
        !pv |=> !start_block_display;
    endproperty
    a_block_cause: assert property (p_block_cause)
        else $error("prevention shown without cause");

    property p_alarm_gate;
        alarm_relay_on && s.phase != PH_LOCK |-> $past(start_block_alarm_enable);
    endproperty
    a_alarm_gate: assert property (p_alarm_gate)
        else $error("alarm driven by prevention while disabled");

    property p_damper;
        $rose(s.phase == PH_TRAV) |-> damper_prepurge ##1 (damper_prepurge || s.phase != PH_TRAV);
    endproperty
    a_damper: assert property (p_damper)
        else $error("damper not at prepurge in travel phase");

    property p_lock_hold;
        q_lock_hold |=> s.phase == PH_LOCK && alarm_relay_on;
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("lockout left without manual reset");
endmodule

//--- testbench/bsc_field.sv
// Field side model: air damper feedback and phase 32 completion.
// Assumes phase and the damper command are registered outputs of the control.
`timescale 1ns/1ps
module bsc_field
    import bsc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       slow,
    input  wire bsc_phase_t phase,
    input  wire logic       damper_prepurge,
    output logic            damper_at_pre,
    output logic            phase32_done
);
    logic [4:0] d_cnt = 5'h00;
    logic [4:0] p_cnt = 5'h00;
    // Travel and proving timers; saturate so a stalled sequence cannot wrap
    always_ff @(posedge clk_sys) begin
        d_cnt <= damper_prepurge ? (d_cnt == 5'h1f ? d_cnt : d_cnt + 5'h01) : 5'h00;
        p_cnt <= (phase == PH_P32) ? (p_cnt == 5'h1f ? p_cnt : p_cnt + 5'h01) : 5'h00;
    end
    // Feedback only while commanded; slow mimics a sluggish actuator
    assign damper_at_pre = damper_prepurge && (d_cnt >= (slow ? 5'h0f : 5'h03));
    assign phase32_done  = (p_cnt >= 5'h05);
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the burner sequence control.
// Assumes a 10-clock tick, and forced and off-time counts of 20 ticks.
`timescale 1ns/1ps
module tb_top
    import bsc_pkg::*;
;
    localparam bsc_fault_t F_NONE = 5'h00;
    localparam bsc_fault_t F_LOOP = 5'h02;
    localparam bsc_fault_t F_LOSS = 5'h04;
    localparam bsc_fault_t F_HEAVY = 5'h08;
    localparam bsc_fault_t F_NOFL = 5'h10;
    logic       clk_sys, sys_rst, heat_req, start_ok, fuel_oil, direct_start, gas_int;
    logic       test_done, checks_ok, man_rst, slow, alarm_en, sb_en, force_en;
    logic       byp_gas, byp_oil, fan_on, loop_on, alarm_on, damper_pre, display;
    logic       damper_at_pre, phase32_done;
    logic [7:0] pv [0:9];
    logic [4:0] lim [0:3];
    logic [1:0] lim_nf;
    bsc_fault_t fault;
    bsc_phase_t phase;
    int         bad_count, n_compared, n, i;

    bsc_ctrl #(.TICK_CYC(10), .FORCE_CNT(20), .OFF_CNT(20)) uut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .heat_req(heat_req), .start_ok(start_ok),
        .fuel_oil(fuel_oil), .direct_start(direct_start), .damper_at_pre(damper_at_pre),
        .phase32_done(phase32_done), .fault(fault), .gas_int(gas_int),
        .safety_test_done(test_done), .safety_checks_ok(checks_ok), .manual_reset(man_rst),
        .lim_start_rel(lim[0]), .lim_loop(lim[1]), .lim_flame_loss(lim[2]),
        .lim_heavy_oil(lim[3]), .lim_no_flame(lim_nf), .start_block_display_delay(pv[8]),
        .start_block_alarm_enable(alarm_en), .alarm_contact_signal_delay(pv[9]),
        .standby_fault_enable(sb_en), .periodic_forced_shutdown_enable(force_en),
        .purge_total_min_gas(pv[0]), .purge_total_min_oil(pv[1]),
        .purge_after_fault_gas(pv[2]), .purge_after_fault_oil(pv[3]),
        .purge_part_one_gas(pv[4]), .purge_part_one_oil(pv[5]),
        .purge_part_three_gas(pv[6]), .purge_part_three_oil(pv[7]),
        .purge_bypass_gas(byp_gas), .purge_bypass_oil(byp_oil), .phase(phase),
        .fan_on(fan_on), .loop_relay_on(loop_on), .alarm_relay_on(alarm_on),
        .damper_prepurge(damper_pre), .start_block_display(display));

    bsc_field field (.clk_sys(clk_sys), .slow(slow), .phase(phase),
        .damper_prepurge(damper_pre), .damper_at_pre(damper_at_pre),
        .phase32_done(phase32_done));

    // 100 ns system clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic c, input string m);
        n_compared++;
        if (c !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    // Bounded wait for a phase, counting clocks spent on the way
    task automatic wait_ph(input bsc_phase_t ph, input int lc, output int k);
        k = 0;
        while (phase !== ph && k < lc) begin
            @(negedge clk_sys);
            k++;
        end
        chk(phase === ph, "phase not reached");
    endtask

    // Both relays are dark while reset is held; the first edge after release
    // already closes the loop relay, and limits latch on that same edge
    task automatic do_reset;
        sys_rst = 1'b1;
        repeat (5) @(negedge clk_sys);
        chk(phase === PH_STBY && alarm_on === 1'b0 && loop_on === 1'b0, "reset state");
        sys_rst = 1'b0;
        @(negedge clk_sys);
        chk(phase === PH_STBY && loop_on === 1'b1, "loop relay after reset");
    endtask

    // Start, then time phases 30 and 34 in ticks with one tick of slack
    task automatic do_start(input int e30, input int e34);
        int k;
        heat_req = 1'b1;
        wait_ph(PH_TRAV, 20, k);
        chk(damper_pre === 1'b1, "damper command");
        wait_ph(PH_P1, 40, k);
        wait_ph(PH_P32, 200, k);
        chk(k >= e30 * 10 - 10 && k <= e30 * 10 + 10, "phase 30 time");
        wait_ph(PH_P3, 40, k);
        wait_ph(PH_RUN, 200, k);
        chk(k >= e34 * 10 - 10 && k <= e34 * 10 + 10, "phase 34 time");
    endtask

    task automatic stop_run;
        int k;
        heat_req = 1'b0;
        wait_ph(PH_STBY, 5, k);
    endtask

    // Fault in run; heat request drops once the fault edge has passed
    task automatic fault_run(input bsc_fault_t f, input logic gi, input bsc_phase_t ex,
                             input int lc, output int k);
        logic f0;
        f0 = fan_on;
        fault = f;
        gas_int = gi;
        @(negedge clk_sys);
        fault = F_NONE;
        gas_int = 1'b0;
        heat_req = 1'b0;
        wait_ph(PH_SAFE, 4, k);
        chk(loop_on === 1'b0 && alarm_on === 1'b0, "relays in safety phase");
        chk(fan_on === f0, "fan not held");
        wait_ph(ex, lc, k);
    endtask

    task automatic unlock;
        int k;
        man_rst = 1'b1;
        wait_ph(PH_STBY, 5, k);
        man_rst = 1'b0;
    endtask

    // Watchdog sized well above the few thousand clocks the tests need
    initial begin
        #1000000;
        bad_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_sim();
    end

    // Main sequence; inputs change at falling edges only
    initial begin
        bad_count = 0;
        n_compared = 0;
        {heat_req, fuel_oil, direct_start, gas_int, man_rst, slow} = 6'h00;
        {alarm_en, sb_en, force_en, byp_gas, byp_oil} = 5'h00;
        {start_ok, test_done, checks_ok} = 3'h7;
        fault = F_NONE;
        pv = '{8'h06, 8'h02, 8'h08, 8'h02, 8'h02, 8'h01, 8'h01, 8'h05, 8'h02, 8'h04};
        lim = '{5'h02, 5'h02, 5'h02, 5'h02};
        lim_nf = 2'h1;
        do_reset();
        do_start(4, 4);
        stop_run();
        slow = 1'b1;
        do_start(2, 4);
        slow = 1'b0;
        fault_run(F_LOSS, 1'b0, PH_STBY, 40, n);
        do_start(2, 4);
        fault_run(F_LOOP, 1'b0, PH_STBY, 40, n);
        do_start(2, 4);
        fault_run(F_LOSS, 1'b0, PH_LOCK, 40, n);
        repeat (50) @(negedge clk_sys);
        chk(phase === PH_LOCK && alarm_on === 1'b1, "lockout not held");
        unlock();
        fuel_oil = 1'b1;
        do_start(3, 5);
        stop_run();
        byp_oil = 1'b1;
        do_start(0, 0);
        stop_run();
        byp_oil = 1'b0;
        fuel_oil = 1'b0;
        byp_gas = 1'b1;
        do_start(0, 0);
        stop_run();
        direct_start = 1'b1;
        do_start(2, 4);
        stop_run();
        direct_start = 1'b0;
        do_start(0, 0);
        fault_run(F_NONE, 1'b1, PH_STBY, 40, n);
        do_start(4, 4);
        byp_gas = 1'b0;
        fault_run(F_NOFL, 1'b0, PH_LOCK, 40, n);
        unlock();
        {test_done, checks_ok} = 2'h0;
        do_start(4, 4);
        fault_run(F_HEAVY, 1'b0, PH_LOCK, 330, n);
        chk(n >= 280 && n <= 310, "safety phase length");
        {test_done, checks_ok} = 2'h3;
        unlock();
        force_en = 1'b1;
        do_start(4, 4);
        wait_ph(PH_STBY, 230, n);
        heat_req = 1'b0;
        chk(n >= 180 && n <= 220, "forced shutdown time");
        force_en = 1'b0;
        repeat (250) @(negedge clk_sys);
        do_start(4, 4);
        stop_run();
        // Start prevention: display and alarm delays from the onset
        start_ok = 1'b0;
        repeat (40) @(negedge clk_sys);
        chk(display === 1'b0, "prevention without heat request");
        heat_req = 1'b1;
        alarm_en = 1'b1;
        n = 0;
        while (display !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        chk(n >= 10 && n <= 30, "display delay");
        while (alarm_on !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        chk(n >= 30 && n <= 50, "alarm delay");
        {heat_req, alarm_en} = 2'h0;
        repeat (3) @(negedge clk_sys);
        heat_req = 1'b1;
        repeat (80) @(negedge clk_sys);
        chk(display === 1'b1 && alarm_on === 1'b0, "alarm while disabled");
        heat_req = 1'b0;
        // Standby fault option turns the prevention into shutdowns
        sb_en = 1'b1;
        wait_ph(PH_SAFE, 5, n);
        wait_ph(PH_LOCK, 100, n);
        sb_en = 1'b0;
        start_ok = 1'b1;
        unlock();
        // New limit stays unused until reset, then sixteen never exhausts
        lim[1] = 5'h10;
        do_start(4, 4);
        fault_run(F_LOOP, 1'b0, PH_STBY, 40, n);
        do_start(2, 4);
        fault_run(F_LOOP, 1'b0, PH_LOCK, 40, n);
        unlock();
        do_reset();
        for (i = 0; i < 3; i++) begin
            do_start(i == 0 ? 4 : 2, 4);
            fault_run(F_LOOP, 1'b0, PH_STBY, 40, n);
        end
        end_sim();
    end
endmodule
